// ---- rtl/thermo_regs_pkg.sv ----
/*
 * Constants shared by the thermocouple channel register bank: register
 * indices, area limits, field positions, reset values and type-area contents.
 * Assumes nothing of its surroundings; every user names package::name.
 */
package thermo_regs_pkg;

	// ----------------------------------------------------------------------
	// Register indices within one channel's set of 64 words.
	// ----------------------------------------------------------------------
	localparam logic [5:0]  IDX_RAW         = 6'h00;
	localparam logic [5:0]  IDX_DIAG        = 6'h06;
	localparam logic [5:0]  IDX_CMD         = 6'h07;
	localparam logic [5:0]  IDX_TYPE        = 6'h08;
	localparam logic [5:0]  IDX_FWVER       = 6'h09;
	localparam logic [5:0]  IDX_DLEN        = 6'h0A;
	localparam logic [5:0]  IDX_SIGCH       = 6'h0B;
	localparam logic [5:0]  IDX_MINLEN      = 6'h0C;
	localparam logic [5:0]  IDX_DTYPE       = 6'h0D;
	localparam logic [5:0]  IDX_RSVD        = 6'h0E;
	localparam logic [5:0]  IDX_ALIGN       = 6'h0F;
	localparam logic [5:0]  IDX_MFR_FIRST   = 6'h10;
	localparam logic [5:0]  IDX_OFS_A       = 6'h11;
	localparam logic [5:0]  IDX_GAIN_A      = 6'h12;
	localparam logic [5:0]  IDX_OFS_H       = 6'h13;
	localparam logic [5:0]  IDX_GAIN_H      = 6'h14;
	localparam logic [5:0]  IDX_CODE        = 6'h1F;
	localparam logic [5:0]  IDX_FEAT        = 6'h20;
	localparam logic [5:0]  IDX_OFS_U       = 6'h21;
	localparam logic [5:0]  IDX_GAIN_U      = 6'h22;
	localparam logic [5:0]  IDX_EXT_FIRST   = 6'h30;

	// ----------------------------------------------------------------------
	// Protection, feature bits and reset values.
	// ----------------------------------------------------------------------
	localparam logic [15:0] CODE_WORD       = 16'h1235;
	localparam int          FEAT_USER_BIT   = 0;
	localparam int          FEAT_MFR_BIT    = 1;
	localparam logic [15:0] FEAT_RESET      = 16'h1006;
	localparam logic [15:0] OFS_A_RESET     = 16'h0000;
	localparam logic [15:0] GAIN_A_RESET    = 16'h3D40;
	localparam logic [15:0] OFS_H_RESET     = 16'h0000;
	localparam logic [15:0] GAIN_H_RESET    = 16'h00A0;
	localparam logic [15:0] OFS_U_RESET     = 16'h0000;
	localparam logic [15:0] GAIN_U_RESET    = 16'h0100;
	localparam logic [15:0] ALIGN_RESET     = 16'h0000;
	localparam logic [15:0] CODE_RESET      = 16'h0000;
	localparam logic [7:0]  FUNC_RESULT     = 8'h00;

	// ----------------------------------------------------------------------
	// Fixed type-area contents. Type and version values are arbitrary.
	// ----------------------------------------------------------------------
	localparam logic [15:0] MODULE_TYPE     = 16'h0C0D;
	localparam logic [15:0] FW_VERSION      = 16'h3141;
	localparam logic [15:0] DATA_LENGTH     = 16'h0110;
	localparam logic [15:0] SIGNAL_CHANNELS = 16'h0001;
	localparam logic [15:0] MIN_DATA_LENGTH = 16'h0082;
	localparam logic [7:0]  DTYPE_NONE      = 8'h00;
	localparam logic [7:0]  DTYPE_BYTES     = 8'h01;
	localparam logic [7:0]  DTYPE_WORDS     = 8'h03;
	localparam logic [7:0]  DTYPE_DWORDS    = 8'h05;
	localparam logic [7:0]  DTYPE_VARLEN    = 8'h10;
	localparam logic [15:0] DATA_TYPE       = {8'h00, DTYPE_WORDS};

	// ----------------------------------------------------------------------
	// Arithmetic scaling and status byte layout.
	// ----------------------------------------------------------------------
	localparam int          GAIN_A_SHIFT    = 14;
	localparam int          SCALE_SHIFT     = 8;
	localparam int          QUAD_SHIFT      = 16;
	localparam int          STAT_UNDER_BIT  = 0;
	localparam int          STAT_OVER_BIT   = 1;
	localparam int          STAT_ERR_BIT    = 6;

endpackage

// ---- rtl/param_store.sv ----
/*
 * Word memory holding the parameter and extended areas of all channels.
 * Assumes one write port and one read port on the same clock; read data
 * appear from a register one cycle after the address.
 */
module param_store #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);

	// Storage has no reset: it stands in for memory that keeps its contents.
	logic [DW-1:0] words [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			words[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= words[raddr];
		end
	end

endmodule

// ---- rtl/channel_register_scaling.sv ----
/*
 * Per-channel register bank and scaling path of a multi-channel thermocouple
 * input. Registers are reached through a word-wide index port; samples arrive
 * as raw converter values with a reference voltage already computed.
 * Assumes all inputs synchronous to clk and one request per cycle.
 */
module channel_register_scaling #(
	parameter int                 NCH = 4,
	parameter logic signed [31:0] QA  = 32'sh0000_0000,
	parameter logic signed [31:0] QB  = 32'sh0001_0000,
	parameter logic signed [31:0] QC  = 32'sh0000_0000
) (
	input  wire logic                                    clk,
	input  wire logic                                    rst_n,
	input  wire logic [$clog2(NCH)-1:0]                  reg_chan,
	input  wire logic [5:0]                              reg_index,
	input  wire logic                                    reg_wr,
	input  wire logic                                    reg_rd,
	input  wire logic [15:0]                             reg_wdata,
	output logic      [15:0]                             reg_rdata,
	output logic                                         reg_rvalid,
	input  wire logic                                    adc_valid,
	input  wire logic [$clog2(NCH)-1:0]                  adc_chan,
	input  wire logic [15:0]                             adc_raw,
	input  wire logic [15:0]                             ref_voltage,
	output logic      [NCH-1:0][15:0]                    process_data,
	output logic                                         pd_valid,
	output logic      [$clog2(NCH)-1:0]                  pd_chan
);

	localparam int CW = $clog2(NCH);

	// ----------------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [NCH-1:0][15:0] align;
		logic [NCH-1:0][15:0] code;
		logic [NCH-1:0][15:0] feat;
		logic [NCH-1:0][15:0] ofs_a;
		logic [NCH-1:0][15:0] gain_a;
		logic [NCH-1:0][15:0] ofs_h;
		logic [NCH-1:0][15:0] gain_h;
		logic [NCH-1:0][15:0] ofs_u;
		logic [NCH-1:0][15:0] gain_u;
		logic [NCH-1:0][15:0] raw;
		logic [NCH-1:0][15:0] pdata;
		logic [NCH-1:0][7:0]  cmd_num;
		logic [NCH-1:0][7:0]  cmd_par;
		logic [NCH-1:0][7:0]  status;
		logic                 rd_p1;
		logic                 use_mem_p1;
		logic [15:0]          flop_p1;
		logic [15:0]          rdata;
		logic                 rvalid;
		logic                 pd_valid;
		logic [CW-1:0]        pd_chan;
	} state_t;

	state_t s;
	state_t next_s;

	// ----------------------------------------------------------------------
	// Arithmetic helpers.
	// ----------------------------------------------------------------------
	function automatic logic signed [31:0] lin(input logic signed [15:0] g,
			input logic signed [31:0] x, input logic signed [15:0] o, input int sh);
		logic signed [47:0] p;
		p = g * x;
		return 32'(p >>> sh) + 32'(o);
	endfunction

	function automatic logic [15:0] sat16(input logic signed [31:0] x);
		logic [15:0] r;
		r = x[15:0];
		if (x > 32'sd32767) begin
			r = 16'h7FFF;
		end else if (x < -32'sd32768) begin
			r = 16'h8000;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------------
	// Measurement and scaling path for the sampled channel.
	// ----------------------------------------------------------------------
	logic signed [31:0] x_in;
	logic signed [31:0] sensor_voltage;
	logic signed [31:0] sum_voltage;
	logic signed [63:0] sq;
	logic signed [31:0] sq_s;
	logic signed [31:0] temp;
	logic signed [31:0] mfr_y;
	logic signed [31:0] usr_in;
	logic signed [31:0] usr_y;
	logic signed [31:0] y;
	logic               mfr_en;
	logic               usr_en;
	logic [15:0]        t_sat;
	logic [15:0]        y_sat;
	logic               unlocked;
	logic               mem_we;
	logic [15:0]        mem_q;

	// Raw value is offset binary around mid-scale; flipping the MSB gives signed.
	assign x_in           = 32'(signed'({~adc_raw[15], adc_raw[14:0]}));
	assign sensor_voltage = lin(s.gain_a[adc_chan], x_in, s.ofs_a[adc_chan],
		thermo_regs_pkg::GAIN_A_SHIFT);
	assign sum_voltage    = sensor_voltage + 32'(signed'(ref_voltage));
	assign sq             = sum_voltage * sum_voltage;
	assign sq_s           = 32'(sq >>> thermo_regs_pkg::QUAD_SHIFT);
	assign temp           = 32'((64'(QA) * 64'(sq_s) + 64'(QB) * 64'(sum_voltage))
		>>> thermo_regs_pkg::QUAD_SHIFT) + QC;
	assign mfr_en         = s.feat[adc_chan][thermo_regs_pkg::FEAT_MFR_BIT];
	assign usr_en         = s.feat[adc_chan][thermo_regs_pkg::FEAT_USER_BIT];
	assign mfr_y          = lin(s.gain_h[adc_chan], temp, s.ofs_h[adc_chan],
		thermo_regs_pkg::SCALE_SHIFT);
	assign usr_in         = mfr_en ? mfr_y : temp;
	assign usr_y          = lin(s.gain_u[adc_chan], usr_in, s.ofs_u[adc_chan],
		thermo_regs_pkg::SCALE_SHIFT);
	assign y              = usr_en ? usr_y : usr_in;
	assign t_sat          = sat16(temp);
	assign y_sat          = sat16(y);
	assign unlocked       = (s.code[reg_chan] == thermo_regs_pkg::CODE_WORD);

	// Manufacturer and user areas are protected; the extended area is not.
	assign mem_we = reg_wr && (reg_index >= thermo_regs_pkg::IDX_MFR_FIRST)
		&& (reg_index != thermo_regs_pkg::IDX_CODE)
		&& ((reg_index >= thermo_regs_pkg::IDX_EXT_FIRST) || unlocked);

	param_store #(
		.AW(CW + 6),
		.DW(16)
	) u_store (
		.clk  (clk),
		.rst_n(rst_n),
		.we   (mem_we),
		.waddr({reg_chan, reg_index}),
		.wdata(reg_wdata),
		.raddr({reg_chan, reg_index}),
		.rdata(mem_q)
	);

	// ----------------------------------------------------------------------
	// Next-state logic.
	// ----------------------------------------------------------------------
	always_comb begin
		next_s            = s;
		next_s.rd_p1      = reg_rd;
		next_s.use_mem_p1 = 1'b0;
		next_s.flop_p1    = 16'h0000;
		next_s.rvalid     = s.rd_p1;
		next_s.pd_valid   = 1'b0;
		if (s.rd_p1) begin
			next_s.rdata = s.use_mem_p1 ? mem_q : s.flop_p1;
		end

		if (reg_rd) begin
			case (reg_index)
				thermo_regs_pkg::IDX_RAW:    next_s.flop_p1 = s.raw[reg_chan];
				thermo_regs_pkg::IDX_DIAG:   next_s.flop_p1 = {8'h00, s.status[reg_chan]};
				thermo_regs_pkg::IDX_CMD:    next_s.flop_p1 = {thermo_regs_pkg::FUNC_RESULT,
					s.cmd_num[reg_chan]};
				thermo_regs_pkg::IDX_TYPE:   next_s.flop_p1 = thermo_regs_pkg::MODULE_TYPE;
				thermo_regs_pkg::IDX_FWVER:  next_s.flop_p1 = thermo_regs_pkg::FW_VERSION;
				thermo_regs_pkg::IDX_DLEN:   next_s.flop_p1 = thermo_regs_pkg::DATA_LENGTH;
				thermo_regs_pkg::IDX_SIGCH:  next_s.flop_p1 = thermo_regs_pkg::SIGNAL_CHANNELS;
				thermo_regs_pkg::IDX_MINLEN: next_s.flop_p1 = thermo_regs_pkg::MIN_DATA_LENGTH;
				thermo_regs_pkg::IDX_DTYPE:  next_s.flop_p1 = thermo_regs_pkg::DATA_TYPE;
				thermo_regs_pkg::IDX_RSVD:   next_s.flop_p1 = 16'h0000;
				thermo_regs_pkg::IDX_ALIGN:  next_s.flop_p1 = s.align[reg_chan];
				thermo_regs_pkg::IDX_OFS_A:  next_s.flop_p1 = s.ofs_a[reg_chan];
				thermo_regs_pkg::IDX_GAIN_A: next_s.flop_p1 = s.gain_a[reg_chan];
				thermo_regs_pkg::IDX_OFS_H:  next_s.flop_p1 = s.ofs_h[reg_chan];
				thermo_regs_pkg::IDX_GAIN_H: next_s.flop_p1 = s.gain_h[reg_chan];
				thermo_regs_pkg::IDX_CODE:   next_s.flop_p1 = unlocked ? thermo_regs_pkg::CODE_WORD
					: 16'h0000;
				thermo_regs_pkg::IDX_FEAT:   next_s.flop_p1 = s.feat[reg_chan];
				thermo_regs_pkg::IDX_OFS_U:  next_s.flop_p1 = s.ofs_u[reg_chan];
				thermo_regs_pkg::IDX_GAIN_U: next_s.flop_p1 = s.gain_u[reg_chan];
				default: begin
					// Unused process indices read zero; the rest come from the store.
					next_s.use_mem_p1 = (reg_index >= thermo_regs_pkg::IDX_MFR_FIRST);
				end
			endcase
		end

		if (reg_wr) begin
			case (reg_index)
				thermo_regs_pkg::IDX_CMD: begin
					next_s.cmd_par[reg_chan] = reg_wdata[15:8];
					next_s.cmd_num[reg_chan] = reg_wdata[7:0];
				end
				thermo_regs_pkg::IDX_ALIGN: next_s.align[reg_chan] = reg_wdata;
				thermo_regs_pkg::IDX_CODE:  next_s.code[reg_chan] = reg_wdata;
				thermo_regs_pkg::IDX_OFS_A: begin
					if (unlocked) begin
						next_s.ofs_a[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_GAIN_A: begin
					if (unlocked) begin
						next_s.gain_a[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_OFS_H: begin
					if (unlocked) begin
						next_s.ofs_h[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_GAIN_H: begin
					if (unlocked) begin
						next_s.gain_h[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_FEAT: begin
					if (unlocked) begin
						next_s.feat[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_OFS_U: begin
					if (unlocked) begin
						next_s.ofs_u[reg_chan] = reg_wdata;
					end
				end
				thermo_regs_pkg::IDX_GAIN_U: begin
					if (unlocked) begin
						next_s.gain_u[reg_chan] = reg_wdata;
					end
				end
				default: begin
					// Type area and reserved index ignore writes.
					next_s.flop_p1 = next_s.flop_p1;
				end
			endcase
		end

		if (adc_valid) begin
			next_s.raw[adc_chan]   = adc_raw;
			next_s.pdata[adc_chan] = y_sat;
			next_s.status[adc_chan] = 8'h00;
			next_s.status[adc_chan][thermo_regs_pkg::STAT_OVER_BIT]  = (y > 32'sd32767);
			next_s.status[adc_chan][thermo_regs_pkg::STAT_UNDER_BIT] = (y < -32'sd32768);
			next_s.status[adc_chan][thermo_regs_pkg::STAT_ERR_BIT]   = (y > 32'sd32767)
				|| (y < -32'sd32768);
			next_s.pd_valid = 1'b1;
			next_s.pd_chan  = adc_chan;
		end
	end

	// ----------------------------------------------------------------------
	// State register.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s        <= '0;
			s.feat   <= {NCH{thermo_regs_pkg::FEAT_RESET}};
			s.ofs_a  <= {NCH{thermo_regs_pkg::OFS_A_RESET}};
			s.gain_a <= {NCH{thermo_regs_pkg::GAIN_A_RESET}};
			s.ofs_h  <= {NCH{thermo_regs_pkg::OFS_H_RESET}};
			s.gain_h <= {NCH{thermo_regs_pkg::GAIN_H_RESET}};
			s.ofs_u  <= {NCH{thermo_regs_pkg::OFS_U_RESET}};
			s.gain_u <= {NCH{thermo_regs_pkg::GAIN_U_RESET}};
			s.align  <= {NCH{thermo_regs_pkg::ALIGN_RESET}};
			s.code   <= {NCH{thermo_regs_pkg::CODE_RESET}};
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata    = s.rdata;
	assign reg_rvalid   = s.rvalid;
	assign process_data = s.pdata;
	assign pd_valid     = s.pd_valid;
	assign pd_chan      = s.pd_chan;

	// ----------------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------------
	AST_RD_LATENCY: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd |-> ##2 reg_rvalid)
		else $error("read answer did not arrive two cycles after the request");

	AST_CMD_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_index == thermo_regs_pkg::IDX_CMD)
		|=> (s.cmd_num[$past(reg_chan)] == 8'($past(reg_wdata))))
		else $error("command number not captured from the low byte");

	AST_FW_VERSION: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_index == thermo_regs_pkg::IDX_FWVER)
		|-> ##2 (reg_rdata == thermo_regs_pkg::FW_VERSION))
		else $error("firmware version read returned the wrong word");

	AST_DATA_TYPE: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_index == thermo_regs_pkg::IDX_DTYPE)
		|-> ##2 (reg_rdata == thermo_regs_pkg::DATA_TYPE))
		else $error("data type read returned the wrong code");

	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_index == thermo_regs_pkg::IDX_RSVD) |-> ##2 (reg_rdata == 16'h0000))
		else $error("reserved type index did not read zero");

	AST_CODE_HIDDEN: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && !reg_wr && reg_index == thermo_regs_pkg::IDX_CODE && !unlocked)
		|-> ##2 (reg_rdata == 16'h0000))
		else $error("code-word readable while protection active");

	AST_PROTECT: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_index == thermo_regs_pkg::IDX_OFS_H && !unlocked) |=> $stable(s.ofs_h))
		else $error("manufacturer offset changed while protected");

	AST_NO_SCALE: assert property (@(posedge clk) disable iff (!rst_n)
		(adc_valid && !mfr_en && !usr_en)
		|=> (pd_valid && process_data[$past(adc_chan)] == $past(t_sat)))
		else $error("unscaled temperature not passed to process data");

	AST_MFR_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
		(adc_valid && mfr_en && !usr_en)
		|=> (process_data[$past(adc_chan)] == sat16($past(mfr_y))))
		else $error("manufacturer scaling result not passed to process data");

endmodule

// ---- tb/coupler_model.sv ----
/*
 * Coupler-side register master that reads and writes one channel word at a time.
 * Assumes the bench calls one task at a time and the bank answers within four cycles.
 */
module coupler_model (
	input  wire logic        clk,
	output logic      [1:0]  reg_chan,
	output logic      [5:0]  reg_index,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	input  wire logic        reg_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_chan = 2'h0;
		reg_index = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	// The command word is sent whole: parameter in the high byte, function number low.
	task automatic wr(input logic [1:0] ch, input logic [5:0] idx, input logic [15:0] d);
		@(posedge clk);
		reg_chan <= ch;
		reg_index <= idx;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Released data shows the inverse so a stale word is never taken as held.
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [1:0] ch, input logic [5:0] idx, output logic [15:0] d, output logic ok);
		@(posedge clk);
		reg_chan <= ch;
		reg_index <= idx;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		ok = 1'b0;
		d = 16'h0000;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge clk);
			if (reg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata;
			end
		end
	endtask
endmodule

// ---- tb/test_channel_register_scaling.sv ----
/*
 * Self-checking bench for the thermocouple register bank and scaling path.
 * Assumes the coupler model drives the register port and default curve coefficients.
 */
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_channel_register_scaling;
	timeunit 1ns;
	timeprecision 1ps;
	logic             clk;
	logic             rst_n;
	logic [1:0]       reg_chan;
	logic [5:0]       reg_index;
	logic             reg_wr;
	logic             reg_rd;
	logic [15:0]      reg_wdata;
	logic [15:0]      reg_rdata;
	logic             reg_rvalid;
	logic             adc_valid;
	logic [1:0]       adc_chan;
	logic [15:0]      adc_raw;
	logic [15:0]      ref_voltage;
	logic [3:0][15:0] process_data;
	logic             pd_valid;
	logic [1:0]       pd_chan;
	int               errors;
	int               cmp_count;
	integer           seed;
	logic [15:0]      rv;
	logic [15:0]      raw;
	logic [15:0]      rf;
	logic             ok;
	localparam logic [15:0] TYPE_VALS [7] = '{16'h0C0D, 16'h3141, 16'h0110, 16'h0001, 16'h0082, 16'h0003, 16'h0000};
	channel_register_scaling dut_u (.clk(clk), .rst_n(rst_n), .reg_chan(reg_chan), .reg_index(reg_index),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.adc_valid(adc_valid), .adc_chan(adc_chan), .adc_raw(adc_raw), .ref_voltage(ref_voltage),
		.process_data(process_data), .pd_valid(pd_valid), .pd_chan(pd_chan));
	coupler_model cpl_u (.clk(clk), .reg_chan(reg_chan), .reg_index(reg_index), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("mismatches %0d of %0d compares", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic rchk(input logic [1:0] ch, input logic [5:0] idx, input logic [15:0] e);
		cpl_u.rd(ch, idx, rv, ok);
		`CHK("read answer", 1'b1, ok)
		if (!ok)
			tally_and_finish();
		else
			`CHK("register", e, rv)
	endtask
	// With default quadratic coefficients the temperature equals the sum voltage.
	function automatic logic [15:0] expect_pd(input logic [15:0] r, f_ref, oh, gu, ou, input logic [1:0] f);
		int t;
		int i;
		int y;
		t = ((int'(thermo_regs_pkg::GAIN_A_RESET) * int'($signed(r ^ 16'h8000))) >>> 14) + int'($signed(f_ref));
		i = f[1] ? ((int'(thermo_regs_pkg::GAIN_H_RESET) * t) >>> 8) + int'($signed(oh)) : t;
		y = f[0] ? ((int'($signed(gu)) * i) >>> 8) + int'($signed(ou)) : i;
		// The output word clamps at the ends of the signed 16-bit range.
		if (y > 32767)
			y = 32767;
		else if (y < -32768)
			y = -32768;
		return y[15:0];
	endfunction
	task automatic sample(input logic [1:0] ch, input logic [15:0] e);
		@(posedge clk);
		adc_valid <= 1'b1;
		adc_chan <= ch;
		adc_raw <= raw;
		ref_voltage <= rf;
		@(posedge clk);
		adc_valid <= 1'b0;
		adc_raw <= ~raw;
		@(negedge clk);
		`CHK("pd_valid", 1'b1, pd_valid)
		`CHK("pd_chan", ch, pd_chan)
		`CHK("process_data", e, process_data[ch])
		@(negedge clk);
		`CHK("pd_valid low", 1'b0, pd_valid)
	endtask
	task automatic draw;
		raw = 16'h8000 + 16'($random(seed) % 8000);
		rf = 16'($random(seed) % 1000);
	endtask
	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		seed = 32'h2b111366;
		errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		adc_valid = 1'b0;
		adc_chan = 2'h0;
		adc_raw = 16'h0000;
		ref_voltage = 16'h0000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		`CHK("pd width", 64, $bits(dut_u.process_data))
		for (int i = 0; i < 7; i++) begin
			cpl_u.wr(2'h1, 6'(8 + i), 16'hA5A5);
			rchk(2'h1, 6'(8 + i), TYPE_VALS[i]);
		end
		rchk(2'h0, thermo_regs_pkg::IDX_DTYPE, 16'h0003);
		rchk(2'h0, thermo_regs_pkg::IDX_MINLEN, 16'h0082);
		`CHK("min length msb", 1'b1, rv[7])
		rchk(2'h0, thermo_regs_pkg::IDX_FWVER, 16'h3141);
		`CHK("ascii", 1'b1, rv[15:8] inside {[8'h20:8'h7E]} && rv[7:0] inside {[8'h20:8'h7E]})
		cpl_u.wr(2'h2, thermo_regs_pkg::IDX_CMD, 16'h5A03);
		rchk(2'h2, thermo_regs_pkg::IDX_CMD, 16'h0003);
		rchk(2'h0, thermo_regs_pkg::IDX_CODE, 16'h0000);
		rchk(2'h0, thermo_regs_pkg::IDX_FEAT, 16'h1006);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_OFS_H, 16'h0003);
		rchk(2'h0, thermo_regs_pkg::IDX_OFS_H, 16'h0000);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_CODE, 16'h1235);
		rchk(2'h0, thermo_regs_pkg::IDX_CODE, 16'h1235);
		rchk(2'h1, thermo_regs_pkg::IDX_CODE, 16'h0000);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_OFS_H, 16'h0003);
		rchk(2'h0, thermo_regs_pkg::IDX_OFS_H, 16'h0003);
		cpl_u.wr(2'h3, thermo_regs_pkg::IDX_ALIGN, 16'h0005);
		rchk(2'h3, thermo_regs_pkg::IDX_ALIGN, 16'h0005);
		cpl_u.wr(2'h1, 6'h30, 16'hBEEF);
		cpl_u.wr(2'h2, 6'h30, 16'h1234);
		rchk(2'h1, 6'h30, 16'hBEEF);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_GAIN_U, 16'h0180);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_OFS_U, 16'hFFF6);
		for (int f = 0; f < 4; f++) begin
			cpl_u.wr(2'h0, thermo_regs_pkg::IDX_FEAT, {thermo_regs_pkg::FEAT_RESET[15:2], 2'(f)});
			repeat (4) begin
				draw();
				sample(2'h0, expect_pd(raw, rf, 16'h0003, 16'h0180, 16'hFFF6, 2'(f)));
			end
		end
		rchk(2'h0, thermo_regs_pkg::IDX_RAW, raw);
		rchk(2'h0, thermo_regs_pkg::IDX_DIAG, 16'h0000);
		repeat (8) begin
			draw();
			adc_chan <= 2'h0;
			sample(2'(1 + ($unsigned($random(seed)) % 3)), expect_pd(raw, rf, 16'h0000, 16'h0100, 16'h0000, 2'b10));
		end
		// Full-scale input and reference drive the scaled value past the top of the range.
		raw = 16'hFFFF;
		rf = 16'h7FFF;
		sample(2'h1, expect_pd(raw, rf, 16'h0000, 16'h0100, 16'h0000, 2'b10));
		rchk(2'h1, thermo_regs_pkg::IDX_DIAG, 16'h0042);
		cpl_u.wr(2'h0, thermo_regs_pkg::IDX_CODE, 16'h0000);
		rchk(2'h0, thermo_regs_pkg::IDX_CODE, 16'h0000);
		tally_and_finish();
	end
endmodule
